// *** common/sdw_pkg.sv ***
// Shared constants and types for the write/close command sequencer.
// Assumes a 250 MHz device clock; commands are decoded outside.
package sdw_pkg;

   localparam int CLK_PERIOD_PS      = 4000;
   localparam int ROW_CLOSE_TIME_PS  = 19000;
   localparam int WRITE_RECOV_PS     = 14000;
   localparam int ROW_CLOSE_CYC      =
      (ROW_CLOSE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WRITE_RECOV_CYC    =
      (WRITE_RECOV_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   localparam int NUM_BANKS   = 4;
   localparam int DATA_W      = 16;
   localparam int ADDR_W      = 13;
   localparam int COL_W       = 9;
   localparam int CNT_W       = 10;
   localparam int AUTO_BIT    = 10;
   localparam int LAT_W       = 2;
   localparam logic [CNT_W-1:0] FULL_PAGE_LEN = 10'h0200;
   localparam logic [CNT_W-1:0] CNT_ZERO      = 10'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE       = 10'h0001;
   localparam logic [3:0]       TMR_ZERO      = 4'h0;
   localparam logic [3:0]       TMR_ONE       = 4'h1;

   typedef enum logic [2:0] {
      SDW_CMD_NOP   = 3'h0,
      SDW_CMD_ACT   = 3'h1,
      SDW_CMD_READ  = 3'h2,
      SDW_CMD_WRITE = 3'h3,
      SDW_CMD_PRE   = 3'h4,
      SDW_CMD_TERM  = 3'h5
   } sdw_cmd_type;

   typedef enum logic [2:0] {
      SDW_IDLE  = 3'b001,
      SDW_WRITE = 3'b010,
      SDW_READ  = 3'b100
   } sdw_burst_type;

   typedef enum logic [2:0] {
      SDW_BK_IDLE  = 3'b001,
      SDW_BK_OPEN  = 3'b010,
      SDW_BK_CLOSE = 3'b100
   } sdw_bank_type;

endpackage : sdw_pkg

// *** verilog/sdw_bank.sv ***
// One bank's row state: idle, open, or closing for the row close time.
// Assumes open/close requests arrive already decoded for this bank.
module sdw_bank
   import sdw_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // Requests
   input  wire logic open_req,
   input  wire logic close_req,
   // Status
   output logic      row_open,
   output logic      row_closing
);
   import sdw_pkg::*;

   sdw_bank_type st_reg, st_next;
   logic [3:0]   tmr_reg, tmr_next;

   always_comb begin
      st_next  = st_reg;
      tmr_next = tmr_reg;
      unique case (st_reg)
         SDW_BK_IDLE: begin
            if (open_req) begin
               st_next = SDW_BK_OPEN;
            end
         end
         SDW_BK_OPEN: begin
            if (close_req) begin
               st_next  = SDW_BK_CLOSE;
               tmr_next = 4'(ROW_CLOSE_CYC - 1);
            end
         end
         SDW_BK_CLOSE: begin
            // A second close here is a no-operation
            if (tmr_reg == TMR_ZERO) begin
               st_next = SDW_BK_IDLE;
            end else begin
               tmr_next = tmr_reg - TMR_ONE;
            end
         end
         default: st_next = SDW_BK_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_reg  <= SDW_BK_IDLE;
         tmr_reg <= TMR_ZERO;
      end else begin
         st_reg  <= st_next;
         tmr_reg <= tmr_next;
      end
   end

   assign row_open    = (st_reg == SDW_BK_OPEN);
   assign row_closing = (st_reg == SDW_BK_CLOSE);

   a_close_lasts : assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(row_closing) |-> row_closing [*5] ##1 !row_closing)
      else $error("Row close did not last the row close time");
endmodule : sdw_bank

// *** verilog/sdw_rdpipe.sv ***
// Read data latency pipe: read word leaves cas latency cycles after issue.
// Assumes the read array answers combinationally on the column address.
module sdw_rdpipe
   import sdw_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // Launch side
   input  wire logic              launch,
   input  wire logic [DATA_W-1:0] launch_data,
   input  wire logic [LAT_W-1:0]  cas_latency,
   // Pin side
   output logic                   dq_oe,
   output logic [DATA_W-1:0]      dq_out
);
   import sdw_pkg::*;

   logic [3:0]        vld_reg, vld_next;
   logic [DATA_W-1:0] dat_reg [4];
   logic [DATA_W-1:0] dat_next [4];

   // Stage 0 holds the word for one cycle; later stages add latency
   always_comb begin
      vld_next    = {vld_reg[2:0], launch};
      dat_next[0] = launch_data;
      for (int i = 1; i < 4; i++) begin
         dat_next[i] = dat_reg[i-1];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         vld_reg <= 4'h0;
         for (int i = 0; i < 4; i++) begin
            dat_reg[i] <= 16'h0000;
         end
      end else begin
         vld_reg <= vld_next;
         for (int i = 0; i < 4; i++) begin
            dat_reg[i] <= dat_next[i];
         end
      end
   end

   assign dq_oe  = vld_reg[cas_latency - LAT_W'(1)];
   assign dq_out = dat_reg[cas_latency - LAT_W'(1)];
endmodule : sdw_rdpipe

// *** verilog/sdw_top.sv ***
// Command sequencer for writes, burst stop and row close in a stacked DRAM.
// Assumes commands are decoded to sdw_cmd_type and sampled on clk_sys.
module sdw_top
   import sdw_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // Command pins
   input  wire logic              clk_en,
   input  wire sdw_cmd_type       cmd,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              bank_select_bit0,
   input  wire logic              bank_select_bit1,
   // Mode settings
   input  wire logic [LAT_W-1:0]  cas_latency,
   input  wire logic [CNT_W-1:0]  burst_len,
   // Data pins
   input  wire logic [DATA_W-1:0] dq_in,
   output logic [DATA_W-1:0]      dq_out,
   output logic                   dq_oe,
   input  wire logic              write_mask,
   // Array write port
   output logic                   arr_we,
   output logic [1:0]             arr_bank,
   output logic [COL_W-1:0]       arr_col,
   output logic [DATA_W-1:0]      arr_wdata,
   // Array read port
   output logic [COL_W-1:0]       arr_rcol,
   input  wire logic [DATA_W-1:0] arr_rdata,
   // Bank status
   output logic [NUM_BANKS-1:0]   bank_open,
   output logic [NUM_BANKS-1:0]   bank_closing
);
   import sdw_pkg::*;

   sdw_burst_type         bst_reg, bst_next;
   logic [CNT_W-1:0]      left_reg, left_next;
   logic [COL_W-1:0]      col_reg, col_next;
   logic [1:0]            bank_reg, bank_next;
   logic                  auto_reg, auto_next;
   logic [3:0]            rec_reg, rec_next;
   logic                  recp_reg, recp_next;
   logic [1:0]            recb_reg, recb_next;
   logic                  we_next;
   logic [COL_W-1:0]      wcol_next;
   logic [DATA_W-1:0]     wdata_next;
   logic [1:0]            wbank_next;
   logic                  we_reg;
   logic [COL_W-1:0]      wcol_reg;
   logic [DATA_W-1:0]     wdata_reg;
   logic [1:0]            wbank_reg;
   logic                  rd_launch;
   logic [1:0]            cmd_bank;
   logic                  auto_close_select_bit;
   logic [NUM_BANKS-1:0]  open_req;
   logic [NUM_BANKS-1:0]  close_req;
   logic [NUM_BANKS-1:0]  auto_close;
   logic [CNT_W-1:0]      blen;

   // Commands are only registered while the clock enable is high
   logic is_cmd_wr, is_cmd_rd, is_cmd_term, is_cmd_pre, is_cmd_act;

   assign cmd_bank              = {bank_select_bit1, bank_select_bit0};
   assign auto_close_select_bit = addr[AUTO_BIT];
   assign is_cmd_wr   = clk_en && (cmd == SDW_CMD_WRITE);
   assign is_cmd_rd   = clk_en && (cmd == SDW_CMD_READ);
   assign is_cmd_term = clk_en && (cmd == SDW_CMD_TERM);
   assign is_cmd_pre  = clk_en && (cmd == SDW_CMD_PRE);
   assign is_cmd_act  = clk_en && (cmd == SDW_CMD_ACT);
   // Zero burst length stands for full page, which never self-ends
   assign blen = (burst_len == CNT_ZERO) ? FULL_PAGE_LEN : burst_len;

   always_comb begin
      bst_next   = bst_reg;
      left_next  = left_reg;
      col_next   = col_reg;
      bank_next  = bank_reg;
      auto_next  = auto_reg;
      rec_next   = rec_reg;
      recp_next  = recp_reg;
      recb_next  = recb_reg;
      we_next    = 1'b0;
      wcol_next  = wcol_reg;
      wdata_next = wdata_reg;
      wbank_next = wbank_reg;
      rd_launch  = 1'b0;
      auto_close = '0;
      // Auto close waits out write recovery after the last word
      if (recp_reg) begin
         if (rec_reg == TMR_ZERO) begin
            recp_next = 1'b0;
            auto_close[recb_reg] = 1'b1;
         end else begin
            rec_next = rec_reg - TMR_ONE;
         end
      end
      if (is_cmd_wr) begin
         // New write takes over any burst in flight
         bst_next   = SDW_WRITE;
         bank_next  = cmd_bank;
         auto_next  = auto_close_select_bit;
         col_next   = addr[COL_W-1:0] + COL_W'(1);
         left_next  = blen - CNT_ONE;
         we_next    = !write_mask;
         wcol_next  = addr[COL_W-1:0];
         wdata_next = dq_in;
         wbank_next = cmd_bank;
         if (blen == CNT_ONE) begin
            bst_next = SDW_IDLE;
            if (auto_close_select_bit) begin
               recp_next = 1'b1;
               rec_next  = 4'(WRITE_RECOV_CYC - 1);
               recb_next = cmd_bank;
            end
         end
      end else if (is_cmd_rd) begin
         // Read ends write capture on this very edge
         bst_next  = SDW_READ;
         bank_next = cmd_bank;
         auto_next = auto_close_select_bit;
         col_next  = addr[COL_W-1:0] + COL_W'(1);
         left_next = blen - CNT_ONE;
         rd_launch = 1'b1;
         if (blen == CNT_ONE) begin
            bst_next = SDW_IDLE;
         end
      end else if (is_cmd_term && !auto_reg) begin
         // Coincident word dropped; applies to the latest burst
         bst_next = SDW_IDLE;
      end else if (is_cmd_pre && !auto_reg && bst_reg != SDW_IDLE
                   && (auto_close_select_bit || cmd_bank == bank_reg)) begin
         bst_next = SDW_IDLE;
      end else if (clk_en && bst_reg != SDW_IDLE) begin
         // Suspended cycles neither capture nor count
         left_next = left_reg - CNT_ONE;
         col_next  = col_reg + COL_W'(1);
         if (bst_reg == SDW_WRITE) begin
            we_next    = !write_mask;
            wcol_next  = col_reg;
            wdata_next = dq_in;
            wbank_next = bank_reg;
         end else begin
            rd_launch = 1'b1;
         end
         if (left_reg == CNT_ONE && burst_len != CNT_ZERO) begin
            bst_next = SDW_IDLE;
            if (auto_reg && bst_reg == SDW_WRITE) begin
               recp_next = 1'b1;
               rec_next  = 4'(WRITE_RECOV_CYC - 1);
               recb_next = bank_reg;
            end else if (auto_reg) begin
               auto_close[bank_reg] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bst_reg   <= SDW_IDLE;
         left_reg  <= 10'h0000;
         col_reg   <= 9'h000;
         bank_reg  <= 2'h0;
         auto_reg  <= 1'b0;
         rec_reg   <= 4'h0;
         recp_reg  <= 1'b0;
         recb_reg  <= 2'h0;
         we_reg    <= 1'b0;
         wcol_reg  <= 9'h000;
         wdata_reg <= 16'h0000;
         wbank_reg <= 2'h0;
      end else begin
         bst_reg   <= bst_next;
         left_reg  <= left_next;
         col_reg   <= col_next;
         bank_reg  <= bank_next;
         auto_reg  <= auto_next;
         rec_reg   <= rec_next;
         recp_reg  <= recp_next;
         recb_reg  <= recb_next;
         we_reg    <= we_next;
         wcol_reg  <= wcol_next;
         wdata_reg <= wdata_next;
         wbank_reg <= wbank_next;
      end
   end

   assign arr_we    = we_reg;
   assign arr_col   = wcol_reg;
   assign arr_wdata = wdata_reg;
   assign arr_bank  = wbank_reg;
   // A read command names its own column, even when it cuts a burst
   assign arr_rcol  = is_cmd_rd ? addr[COL_W-1:0] : col_reg;

   genvar b;
   generate
      for (b = 0; b < NUM_BANKS; b++) begin : g_bank
         // Bit ten high closes all banks, else bank select names one
         assign close_req[b] = auto_close[b] || (is_cmd_pre &&
            (auto_close_select_bit || cmd_bank == 2'(b)));
         assign open_req[b] = is_cmd_act && cmd_bank == 2'(b);
         sdw_bank u_bank (
            .clk_sys     (clk_sys),
            .rst_n       (rst_n),
            .open_req    (open_req[b]),
            .close_req   (close_req[b]),
            .row_open    (bank_open[b]),
            .row_closing (bank_closing[b])
         );
      end
   endgenerate

   // Pins are driven only by the read pipe; writes leave them undriven
   sdw_rdpipe u_rdpipe (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n),
      .launch      (rd_launch),
      .launch_data (arr_rdata),
      .cas_latency (cas_latency),
      .dq_oe       (dq_oe),
      .dq_out      (dq_out)
   );

   sequence s_masked_write;
      is_cmd_wr && write_mask;
   endsequence

   a_wr_capture : assert property (@(posedge clk_sys) disable iff (!rst_n)
      is_cmd_wr && !write_mask |=> arr_we && arr_wdata == $past(dq_in))
      else $error("Write word not captured with command");
   a_mask_block : assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_masked_write |=> !arr_we)
      else $error("Masked word was written");
   a_idle_quiet : assert property (@(posedge clk_sys) disable iff (!rst_n)
      bst_reg == SDW_IDLE && !is_cmd_wr |=> !arr_we)
      else $error("Write after burst end");
   a_term_drop : assert property (@(posedge clk_sys) disable iff (!rst_n)
      is_cmd_term && !auto_reg |=> !arr_we ##1 (!arr_we || $past(is_cmd_wr)))
      else $error("Burst stop did not drop data");
   a_suspend_hold : assert property (@(posedge clk_sys) disable iff (!rst_n)
      !clk_en |=> !arr_we && $stable(left_reg))
      else $error("Write progressed while suspended");
   a_read_stop : assert property (@(posedge clk_sys) disable iff (!rst_n)
      is_cmd_rd |=> !arr_we && bst_reg != SDW_WRITE)
      else $error("Write continued after read");
   a_all_close : assert property (@(posedge clk_sys) disable iff (!rst_n)
      is_cmd_pre && auto_close_select_bit
      |=> bank_open == 4'h0
          && (bank_closing & $past(bank_open)) == $past(bank_open))
      else $error("Close all missed a bank");
   a_pipe_lat : assert property (@(posedge clk_sys) disable iff (!rst_n)
      is_cmd_rd && cas_latency == 2'h2 |-> ##2 dq_oe)
      else $error("Read data not at cas latency");
endmodule : sdw_top

// *** testbench/sdw_ctrl_model.sv ***
// Controller-side model: commands, address, mask and write data.
// Assumes the bench calls its tasks in sequence; one cyc call is one clock.
module sdw_ctrl_model
   import sdw_pkg::*;
(
   // Clock
   input  wire logic         clk_sys,
   // Command pins
   output sdw_cmd_type       cmd,
   output logic [ADDR_W-1:0] addr,
   output logic              bank_select_bit0,
   output logic              bank_select_bit1,
   output logic              clk_en,
   // Data pins
   output logic [DATA_W-1:0] dq_in,
   output logic              write_mask
);
   timeunit 1ns;
   timeprecision 1ps;
   // Row open limit, 45 ns rounded up to whole cycles
   localparam int ROW_OPEN_CYC = 12;

   initial begin
      cmd = SDW_CMD_NOP;
      addr = '0;
      bank_select_bit0 = 1'b0;
      bank_select_bit1 = 1'b0;
      clk_en = 1'b1;
      dq_in = 16'h5a5a;
      write_mask = 1'b0;
   end

   task automatic cyc(input sdw_cmd_type c, input logic [12:0] a,
                      input logic [1:0] b, input logic [15:0] d,
                      input logic m, input logic ke);
      @(posedge clk_sys);
      cmd <= c;
      addr <= a;
      bank_select_bit0 <= b[0];
      bank_select_bit1 <= b[1];
      dq_in <= d;
      write_mask <= m;
      clk_en <= ke;
   endtask : cyc

   // Idle data keeps moving so a stale word never looks like a fresh one
   task automatic idle(input int n);
      for (int k = 0; k < n; k++)
         cyc(SDW_CMD_NOP, 13'(~dq_in), dq_in[1:0], ~dq_in ^ 16'(k),
             dq_in[2], 1'b1);
   endtask : idle

   task automatic act(input logic [1:0] b);
      idle(ROW_CLOSE_CYC);
      cyc(SDW_CMD_ACT, '0, b, ~dq_in, 1'b0, 1'b1);
      idle(ROW_CLOSE_CYC);
   endtask : act

   // Closes only come after bursts are over, never mid-burst
   task automatic pre(input logic all, input logic [1:0] b);
      idle(ROW_OPEN_CYC);
      cyc(SDW_CMD_PRE, {2'b00, all, 10'h000}, b, ~dq_in, 1'b0, 1'b1);
   endtask : pre
endmodule : sdw_ctrl_model

// *** testbench/sdw_write_precharge_cmds_tb.sv ***
// Self-checking bench for the write/close sequencer.
// Assumes sdw_top and the controller model; array reads return a pattern.
module sdw_write_precharge_cmds_tb;
   import sdw_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_sys, rst_n, clk_en, bs0, bs1, write_mask, dq_oe, arr_we;
   sdw_cmd_type              cmd;
   logic [ADDR_W-1:0]        addr;
   logic [LAT_W-1:0]         cas_latency;
   logic [CNT_W-1:0]         burst_len;
   logic [DATA_W-1:0]        ctrl_dq, dq_wire, dq_out, arr_wdata, arr_rdata;
   logic [1:0]               arr_bank;
   logic [COL_W-1:0]         arr_col, arr_rcol;
   logic [NUM_BANKS-1:0]     bank_open, bank_closing;
   logic [26:0]              wq[$];
   logic [15:0]              rq[$];
   logic [31:0]              seed = 32'haa0b_b7b4;
   int                       fail_count = 0;
   int                       n_compared = 0;
   int                       n_close = 0;

   // Device only drives the shared data wire while reading
   assign dq_wire = dq_oe ? dq_out : ctrl_dq;
   assign arr_rdata = {7'h55, arr_rcol};

   sdw_ctrl_model u_ctrl (.clk_sys(clk_sys), .cmd(cmd), .addr(addr),
      .bank_select_bit0(bs0), .bank_select_bit1(bs1), .clk_en(clk_en),
      .dq_in(ctrl_dq), .write_mask(write_mask));

   sdw_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
      .cmd(cmd), .addr(addr), .bank_select_bit0(bs0),
      .bank_select_bit1(bs1), .cas_latency(cas_latency),
      .burst_len(burst_len), .dq_in(dq_wire), .dq_out(dq_out),
      .dq_oe(dq_oe), .write_mask(write_mask), .arr_we(arr_we),
      .arr_bank(arr_bank), .arr_col(arr_col), .arr_wdata(arr_wdata),
      .arr_rcol(arr_rcol), .arr_rdata(arr_rdata), .bank_open(bank_open),
      .bank_closing(bank_closing));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   function automatic logic [15:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[15:0];
   endfunction : rnd

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   // Write burst with an optional stop command, suspend pair and mask slot
   task automatic wr_seq(input logic [1:0] bk, input logic [8:0] col,
                         input int len, input logic auto, input int stop_at,
                         input sdw_cmd_type stop, input int susp,
                         input int mask_at);
      int          k;
      sdw_cmd_type c;
      logic [15:0] d;
      logic [12:0] a;
      logic        q;
      k = 0;
      for (int i = 0; i < len + 4; i++) begin
         d = rnd();
         if (i == stop_at && stop == SDW_CMD_WRITE)
            return;
         c = (i == 0) ? SDW_CMD_WRITE : (i == stop_at) ? stop : SDW_CMD_NOP;
         a = (c == SDW_CMD_READ) ? 13'h0008 : {2'b00, auto, 1'b0, col};
         if (i >= susp && i < susp + 2) begin
            u_ctrl.cyc(SDW_CMD_NOP, a, bk, d, 1'b0, 1'b0);
         end else begin
            // Once the burst has no more slots, pins carry random noise
            q = k >= len || (i > stop_at && !(auto && stop == SDW_CMD_TERM));
            u_ctrl.cyc(c, q ? 13'(rnd()) : a, q ? d[15:14] : bk, d,
                       q ? d[0] : i == mask_at, 1'b1);
            if ((i < stop_at || (auto && stop == SDW_CMD_TERM)) && k < len
                && i != mask_at)
               wq.push_back({bk, col + k[8:0], d});
            if (c == SDW_CMD_READ)
               for (int j = 0; j < len; j++)
                  rq.push_back({7'h55, 9'h008 + j[8:0]});
            k++;
         end
      end
   endtask : wr_seq

   // Oldest note is taken whenever the design shows a result
   always @(posedge clk_sys) begin
      if (rst_n === 1'b1 && arr_we === 1'b1) begin
         if (wq.size() == 0)
            check("unexpected_write", 32'h1, 32'h0);
         else
            check("array_write", {arr_bank, arr_col, arr_wdata},
                  wq.pop_front());
      end
      if (rst_n === 1'b1 && dq_oe === 1'b1) begin
         if (rq.size() == 0)
            check("unexpected_read", 32'h1, 32'h0);
         else
            check("read_data", dq_out, rq.pop_front());
      end
      if (bank_closing[1] === 1'b1)
         n_close++;
   end

   initial begin
      #20000;
      fail_count++;
      $display("watchdog expired");
      summarize();
   end

   initial begin
      rst_n = 1'b0;
      cas_latency = 2'd2;
      burst_len = 10'h0004;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int b = 0; b < NUM_BANKS; b++)
         u_ctrl.act(2'(b));
      wr_seq(2'd1, 9'h005, 4, 1'b0, 99, SDW_CMD_NOP, 99, 2);
      $display("test mask finished");
      wr_seq(2'd0, 9'h000, 4, 1'b0, 2, SDW_CMD_WRITE, 99, -1);
      wr_seq(2'd0, 9'h010, 4, 1'b0, 99, SDW_CMD_NOP, 99, -1);
      $display("test chain finished");
      wr_seq(2'd2, 9'h020, 4, 1'b0, 99, SDW_CMD_NOP, 1, -1);
      $display("test suspend finished");
      for (int cl = 2; cl < 4; cl++) begin
         cas_latency <= 2'(cl);
         wr_seq(2'd3, 9'h030, 4, 1'b0, 2, SDW_CMD_READ, 99, -1);
         u_ctrl.idle(8);
      end
      $display("test write_to_read finished");
      burst_len <= 10'h0000;
      wr_seq(2'd0, 9'h1fe, 512, 1'b0, 4, SDW_CMD_TERM, 99, -1);
      $display("test full_page finished");
      burst_len <= 10'h0004;
      wr_seq(2'd2, 9'h040, 4, 1'b1, 2, SDW_CMD_TERM, 99, -1);
      u_ctrl.idle(20);
      check("auto_close", bank_open[2], 32'h0);
      u_ctrl.act(2'd2);
      wr_seq(2'd2, 9'h050, 4, 1'b0, 99, SDW_CMD_NOP, 99, -1);
      u_ctrl.idle(20);
      check("no_carry_over", bank_open[2], 32'h1);
      $display("test auto_close finished");
      n_close = 0;
      u_ctrl.pre(1'b0, 2'd1);
      u_ctrl.cyc(SDW_CMD_PRE, 13'h0000, 2'd1, rnd(), 1'b0, 1'b1);
      u_ctrl.idle(12);
      check("close_cycles", n_close, ROW_CLOSE_CYC);
      check("one_bank", bank_open, 32'hd);
      u_ctrl.pre(1'b0, 2'd1);
      u_ctrl.idle(3);
      check("idle_close", bank_closing, 32'h0);
      u_ctrl.pre(1'b1, 2'd1);
      u_ctrl.idle(12);
      check("all_banks", bank_open, 32'h0);
      $display("test precharge finished");
      u_ctrl.idle(10);
      check("writes_left", wq.size(), 32'h0);
      check("reads_left", rq.size(), 32'h0);
      summarize();
   end
endmodule : sdw_write_precharge_cmds_tb
